// ---- common/board_regs_defines.svh ----
`ifndef BOARD_REGS_DEFINES_SVH
`define BOARD_REGS_DEFINES_SVH

// register block bases per jumper pair {b,a}
`define REG_BASE_NONE 10'h100
`define REG_BASE_A 10'h110
`define REG_BASE_B 10'h120
`define REG_BASE_AB 10'h130

// ethernet controller window bases per jumper pair {b,a}
`define MAC_BASE_NONE 10'h200
`define MAC_BASE_A 10'h240
`define MAC_BASE_B 10'h300
`define MAC_BASE_AB 10'h340

// register offsets inside the block
`define OFF_BOARD_ID 4'h0
`define OFF_LOGIC_REV 4'h4
`define OFF_JUMPER 4'h8
`define OFF_POWER 4'hC

// decode geometry
`define BASE_ADDR_BITS 10
`define BLOCK_LSB 4
`define SEL_LSB 2
`define MAC_BASE_ALIGN_BITS 6

// jumper_status field positions
`define JMP_WIDE_BIT 0
`define JMP_IRQ_FIRST_BIT 1
`define JMP_IRQ_SECOND_BIT 2
`define JMP_IRQ_THIRD_BIT 3

// bus_power_control layout, register width and host interrupt line count
`define POWER_EN_BIT 0
`define POWER_RESET 1'b1
`define REG_WIDTH 4
`define REG_ZERO 4'h0
`define IRQ_LINES 3

`endif

// ---- common/board_regs_pkg.sv ----
`default_nettype none
`include "board_regs_defines.svh"
package board_regs_pkg;
  // which of the four registers an access addresses
  typedef enum logic [1:0] {
    SEL_BOARD_ID = 2'b00,
    SEL_LOGIC_REV = 2'b01,
    SEL_JUMPER = 2'b10,
    SEL_POWER = 2'b11
  } reg_sel_type;

  // phase of the host i/o cycle as seen by the register bank
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_READ = 2'b01,
    BUS_WRITE = 2'b10
  } bus_state_type;
endpackage
`default_nettype wire

// ---- logic/board_addr_decode.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "board_regs_defines.svh"
module board_addr_decode #(
  parameter int ADDR_WIDTH = 10,
  parameter int MAC_SPAN_BITS = 5
) (
  input wire logic [ADDR_WIDTH-1:0] i_addr,
  input wire logic i_aen,
  input wire logic i_base_a,
  input wire logic i_base_b,
  output logic o_reg_hit,
  output board_regs_pkg::reg_sel_type o_reg_sel,
  output logic o_mac_hit
);
  import board_regs_pkg::*;

  logic [ADDR_WIDTH-1:0] reg_base; // selected register block base
  logic [ADDR_WIDTH-1:0] mac_base; // selected ethernet window base

  // the address must reach the fixed bases and the window must fit
  // inside the 0x40 spacing of the ethernet bases
  if (ADDR_WIDTH < `BASE_ADDR_BITS) begin : g_bad_width
    $error("address width too narrow for the base table");
  end
  if (MAC_SPAN_BITS < `BLOCK_LSB || MAC_SPAN_BITS > `MAC_BASE_ALIGN_BITS)
  begin : g_bad_span
    $error("ethernet window span out of range");
  end

  // both bases move together with the jumper pair
  always_comb begin
    case ({i_base_b, i_base_a})
      2'b00: begin
        reg_base = ADDR_WIDTH'(`REG_BASE_NONE);
        mac_base = ADDR_WIDTH'(`MAC_BASE_NONE);
      end
      2'b01: begin
        reg_base = ADDR_WIDTH'(`REG_BASE_A);
        mac_base = ADDR_WIDTH'(`MAC_BASE_A);
      end
      2'b10: begin
        reg_base = ADDR_WIDTH'(`REG_BASE_B);
        mac_base = ADDR_WIDTH'(`MAC_BASE_B);
      end
      default: begin
        reg_base = ADDR_WIDTH'(`REG_BASE_AB);
        mac_base = ADDR_WIDTH'(`MAC_BASE_AB);
      end
    endcase
  end

  // aen high means a dma cycle owns the bus; never answer then
  always_comb begin
    o_reg_hit = !i_aen
      && (i_addr[ADDR_WIDTH-1:`BLOCK_LSB]
          == reg_base[ADDR_WIDTH-1:`BLOCK_LSB])
      && (i_addr[`SEL_LSB-1:0] == '0);
    o_reg_sel = reg_sel_type'(i_addr[`BLOCK_LSB-1:`SEL_LSB]);
    o_mac_hit = !i_aen
      && (i_addr[ADDR_WIDTH-1:MAC_SPAN_BITS]
          == mac_base[ADDR_WIDTH-1:MAC_SPAN_BITS]);
  end
endmodule // board_addr_decode
`default_nettype wire

// ---- logic/board_regs.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "board_regs_defines.svh"
module board_regs #(
  parameter int ADDR_WIDTH = 10,
  parameter int MAC_SPAN_BITS = 5,
  // arbitrary neutral identification value
  parameter logic [3:0] BOARD_ID = 4'hA,
  // revision of this glue logic image
  parameter logic [3:0] LOGIC_REVISION = 4'h1
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic [ADDR_WIDTH-1:0] i_sa,
  input wire logic i_aen,
  input wire logic i_ior_n,
  input wire logic i_iow_n,
  input wire logic [7:0] i_sd,
  output logic [7:0] o_sd,
  output logic o_sd_oe,
  input wire logic i_base_select_jumper_a,
  input wire logic i_base_select_jumper_b,
  input wire logic i_irq_select_jumper_first,
  input wire logic i_irq_select_jumper_second,
  input wire logic i_irq_select_jumper_third,
  input wire logic i_wide_mode_jumper,
  input wire logic i_mac_irq,
  output logic [`IRQ_LINES-1:0] o_host_irq,
  output logic o_mac_cs_n,
  output logic o_mac_wide_mode,
  output logic o_bus_power_en,
  output board_regs_pkg::bus_state_type o_bus_state
);
  import board_regs_pkg::*;

  // decoder results for the current address
  logic reg_hit;
  reg_sel_type reg_sel;
  logic mac_hit;

  // cycle tracking
  bus_state_type state; // current host cycle phase
  bus_state_type next_state; // phase for the next edge
  reg_sel_type cycle_sel; // register addressed by the open cycle
  logic cycle_hit; // open cycle targets this bank

  // register contents
  logic [`REG_WIDTH-1:0] jumper_status; // sampled jumper image
  logic power_en; // the only writable bit
  logic write_data; // data bit held while the write strobe is low
  logic write_armed; // a power write is waiting for strobe release

  // read path
  logic [`REG_WIDTH-1:0] next_read_value; // mux of the four registers
  logic [7:0] read_data; // registered byte driven on the bus
  logic read_drive; // registered output enable

  // per-line interrupt routing
  logic [`IRQ_LINES-1:0] irq_select; // jumper per host line
  logic [`IRQ_LINES-1:0] host_irq; // registered routed interrupt

  // base and window follow the two address jumpers
  board_addr_decode #(
    .ADDR_WIDTH(ADDR_WIDTH),
    .MAC_SPAN_BITS(MAC_SPAN_BITS)
  ) u_decode (
    .i_addr(i_sa),
    .i_aen(i_aen),
    .i_base_a(i_base_select_jumper_a),
    .i_base_b(i_base_select_jumper_b),
    .o_reg_hit(reg_hit),
    .o_reg_sel(reg_sel),
    .o_mac_hit(mac_hit)
  );

  // choose the next cycle phase; a strobe pair both low opens no
  // cycle from idle since a legal host never asserts both
  always_comb begin
    case (state)
      BUS_IDLE: begin
        if (!i_ior_n && i_iow_n) begin
          next_state = BUS_READ;
        end else if (!i_iow_n && i_ior_n) begin
          next_state = BUS_WRITE;
        end else begin
          next_state = BUS_IDLE;
        end
      end
      BUS_READ: begin
        // stay until the read strobe is released
        next_state = i_ior_n ? BUS_IDLE : BUS_READ;
      end
      BUS_WRITE: begin
        // the write lands on the edge that leaves this phase
        next_state = i_iow_n ? BUS_IDLE : BUS_WRITE;
      end
      default: begin
        next_state = BUS_IDLE;
      end
    endcase
  end

  // phase register
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      state <= BUS_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // latch the target of a cycle at its start; the address is held
  // by the host for the whole strobe, so one look is enough
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      cycle_hit <= 1'b0;
      cycle_sel <= SEL_BOARD_ID;
    end else if (state == BUS_IDLE && next_state != BUS_IDLE) begin
      cycle_hit <= reg_hit;
      cycle_sel <= reg_sel;
    end else if (next_state == BUS_IDLE) begin
      cycle_hit <= 1'b0;
    end
  end

  // jumpers are static straps; sampling them each clock keeps the
  // image current if someone moves one with power applied
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      jumper_status <= `REG_ZERO;
    end else begin
      jumper_status[`JMP_WIDE_BIT] <= i_wide_mode_jumper;
      jumper_status[`JMP_IRQ_FIRST_BIT] <= i_irq_select_jumper_first;
      jumper_status[`JMP_IRQ_SECOND_BIT] <= i_irq_select_jumper_second;
      jumper_status[`JMP_IRQ_THIRD_BIT] <= i_irq_select_jumper_third;
    end
  end

  // keep the data bit while the write strobe is low; the isa data
  // is only sure to be valid late in the strobe, so the last value
  // seen before release is the one that counts
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      write_data <= 1'b0;
      write_armed <= 1'b0;
    end else if (state == BUS_WRITE && !i_iow_n) begin
      write_data <= i_sd[`POWER_EN_BIT];
      // only the power register accepts data; others drop it
      write_armed <= reg_hit && reg_sel == SEL_POWER;
    end else begin
      write_armed <= 1'b0;
    end
  end

  // commit on strobe release; bits 3 to 1 have no storage at all
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      power_en <= `POWER_RESET;
    end else if (state == BUS_WRITE && i_iow_n && write_armed) begin
      power_en <= write_data;
    end
  end

  // read mux; reserved power bits are constant zero
  always_comb begin
    case (cycle_sel)
      SEL_BOARD_ID: begin
        next_read_value = BOARD_ID;
      end
      SEL_LOGIC_REV: begin
        next_read_value = LOGIC_REVISION;
      end
      SEL_JUMPER: begin
        next_read_value = jumper_status;
      end
      SEL_POWER: begin
        next_read_value = `REG_ZERO;
        next_read_value[`POWER_EN_BIT] = power_en;
      end
      default: begin
        next_read_value = `REG_ZERO;
      end
    endcase
  end

  // drive the data lanes only while our read strobe is low; the
  // two clocks of lag are far inside a host read strobe
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      read_data <= 8'h00;
      read_drive <= 1'b0;
    end else if (state == BUS_READ && !i_ior_n && cycle_hit) begin
      read_data <= {4'h0, next_read_value};
      read_drive <= 1'b1;
    end else begin
      read_data <= 8'h00;
      read_drive <= 1'b0;
    end
  end

  // one gate per host line; exactly one jumper should be fitted,
  // two fitted jumpers would share the interrupt on both lines
  assign irq_select = {i_irq_select_jumper_third,
                       i_irq_select_jumper_second,
                       i_irq_select_jumper_first};
  for (genvar g = 0; g < `IRQ_LINES; g++) begin : g_irq
    always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
        host_irq[g] <= 1'b0;
      end else begin
        host_irq[g] <= i_mac_irq && irq_select[g];
      end
    end
  end

  // wide mode tells the controller to use 16-bit lanes on the small
  // connector; without the jumper the host must use byte accesses
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_mac_wide_mode <= 1'b0;
    end else begin
      o_mac_wide_mode <= i_wide_mode_jumper;
    end
  end

  // the ethernet select is combinational so the controller sees the
  // same timing the host gives; the bank never drives data then
  assign o_mac_cs_n = !mac_hit;
  assign o_sd = read_data;
  assign o_sd_oe = read_drive;
  assign o_host_irq = host_irq;
  assign o_bus_power_en = power_en;
  assign o_bus_state = state;
endmodule // board_regs
`default_nettype wire

// ---- test/board_regs_chk.sv ----
`timescale 1ns/1ns
`default_nettype none
module board_regs_chk #(
  parameter int ADDR_WIDTH = 10,
  parameter logic [3:0] BOARD_ID = 4'hA
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic [ADDR_WIDTH-1:0] i_sa,
  input wire logic i_aen,
  input wire logic i_ior_n,
  input wire logic i_iow_n,
  input wire logic [7:0] i_sd,
  input wire logic [7:0] o_sd,
  input wire logic o_sd_oe,
  input wire logic i_base_select_jumper_a,
  input wire logic i_base_select_jumper_b,
  input wire logic i_irq_select_jumper_first,
  input wire logic i_irq_select_jumper_second,
  input wire logic i_irq_select_jumper_third,
  input wire logic i_wide_mode_jumper,
  input wire logic i_mac_irq,
  input wire logic [2:0] o_host_irq,
  input wire logic o_mac_cs_n,
  input wire logic o_mac_wide_mode,
  input wire logic o_bus_power_en,
  input wire logic [1:0] o_bus_state
);
  localparam logic [3:0][9:0] MAC = {10'h340, 10'h300, 10'h240, 10'h200};
  logic [1:0] sel; // jumper pair {b,a}
  logic [9:0] base; // register block base
  logic reg_hit; // aligned access inside the block
  logic pwr_hit;
  logic id_hit;
  logic [2:0] irq_want; // interrupt lines the jumpers ask for
  logic sd_bit;
  assign sel = {i_base_select_jumper_b, i_base_select_jumper_a};
  assign base = 10'h100 + {4'h0, sel, 4'h0};
  assign reg_hit = !i_aen && i_sa[9:4] == base[9:4] && i_sa[1:0] == 2'h0;
  assign pwr_hit = reg_hit && i_sa[3:2] == 2'h3;
  assign id_hit = reg_hit && i_sa[3:2] == 2'h0;
  assign irq_want = {i_irq_select_jumper_third, i_irq_select_jumper_second,
    i_irq_select_jumper_first} & {3{i_mac_irq}};
  assign sd_bit = i_sd[0];
  // one clock domain, so one clocking and one disable
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_rst);
  upper_zero_a: assert property (o_sd_oe |-> o_sd[7:4] == 4'h0)
    else $error("read data upper nibble not zero");
  id_read_a: assert property ($fell(i_ior_n) && i_iow_n && id_hit
    |-> ##2 o_sd_oe && o_sd[3:0] == BOARD_ID)
    else $error("board code not returned two edges after strobe");
  no_answer_a: assert property ($fell(i_ior_n) && !reg_hit
    |-> ##2 !o_sd_oe)
    else $error("bank answered outside its block");
  oe_drop_a: assert property ($rose(i_ior_n) |-> ##1 !o_sd_oe)
    else $error("read data held after strobe release");
  mac_cs_a: assert property (
    o_mac_cs_n == !(!i_aen && i_sa[9:5] == MAC[sel][9:5]))
    else $error("ethernet select wrong for address");
  irq_route_a: assert property (!$past(i_rst)
    |-> o_host_irq == $past(irq_want))
    else $error("host interrupt lines do not follow jumpers");
  wide_copy_a: assert property (!$past(i_rst)
    |-> o_mac_wide_mode == $past(i_wide_mode_jumper))
    else $error("wide mode not forwarded");
  power_write_a: assert property ($rose(i_iow_n) && $past(pwr_hit)
    && $past(i_ior_n) |-> ##1 o_bus_power_en == $past(sd_bit, 2))
    else $error("power bit not written");
  power_hold_a: assert property (
    !$rose(i_iow_n) |=> $stable(o_bus_power_en))
    else $error("power bit changed without a write");
  // a strobe that opens from a quiet bus must move the phase next edge
  read_phase_a: assert property ($fell(i_ior_n) && i_iow_n
    && $past(i_iow_n) |-> ##1 o_bus_state == 2'h1)
    else $error("read phase not entered after strobe");
  write_phase_a: assert property ($fell(i_iow_n) && i_ior_n
    && $past(i_ior_n) |-> ##1 o_bus_state == 2'h2)
    else $error("write phase not entered after strobe");
endmodule // board_regs_chk

bind board_regs board_regs_chk #(
  .ADDR_WIDTH(ADDR_WIDTH),
  .BOARD_ID(BOARD_ID)
) i_chk (.*);
`default_nettype wire

// ---- test/isa_host.sv ----
`timescale 1ns/1ns
`default_nettype none
module isa_host (
  input wire logic i_clk,
  input wire logic [7:0] i_sd,
  input wire logic i_sd_oe,
  output logic [9:0] o_sa,
  output logic o_aen,
  output logic o_ior_n,
  output logic o_iow_n,
  output logic [7:0] o_sd
);
  initial begin
    o_sa = 10'h3FF;
    o_aen = 1'b0;
    o_ior_n = 1'b1;
    o_iow_n = 1'b1;
    o_sd = 8'h00;
  end
  // byte read; strobe held until the bank drives, bounded by four edges
  task automatic rd(input logic [9:0] a, input logic dma,
      output logic [7:0] d, output logic got);
    @(posedge i_clk);
    o_sa <= a;
    o_aen <= dma;
    o_ior_n <= 1'b0;
    got = 1'b0;
    d = 8'h00;
    for (int n = 0; n < 4 && !got; n++) begin
      @(posedge i_clk);
      got = i_sd_oe === 1'b1;
      d = i_sd;
    end
    o_ior_n <= 1'b1;
    o_aen <= 1'b0;
  endtask
  // byte write; strobe low three edges, then data line is let go
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge i_clk);
    o_sa <= a;
    o_sd <= d;
    o_iow_n <= 1'b0;
    repeat (3) @(posedge i_clk);
    o_iow_n <= 1'b1;
    repeat (2) @(posedge i_clk);
    o_sd <= ~d; // released line shows no stale value
  endtask
  // address only, no strobe; returns settled at the falling edge
  task automatic put(input logic [9:0] a);
    @(posedge i_clk);
    o_sa <= a;
    @(negedge i_clk);
  endtask
endmodule // isa_host
`default_nettype wire

// ---- test/tb_board_regs.sv ----
`timescale 1ns/1ns
`default_nettype none
module tb_board_regs;
  import board_regs_pkg::*;
  typedef struct packed {
    logic [1:0] sel;
    logic [3:0] jmp; // {third, second, first, wide}
    logic [3:0] off;
    logic [7:0] exp;
  } row_type;
  localparam logic [3:0][9:0] MAC = {10'h340, 10'h300, 10'h240, 10'h200};
  localparam row_type ROWS [8] = '{'{2'h0, 4'h0, 4'h0, 8'h0A},
    '{2'h1, 4'h5, 4'h4, 8'h03}, '{2'h2, 4'h9, 4'h8, 8'h09},
    '{2'h3, 4'h6, 4'h8, 8'h06}, '{2'h3, 4'hF, 4'h0, 8'h0A},
    '{2'h1, 4'h2, 4'h8, 8'h02}, '{2'h0, 4'h4, 4'hC, 8'h01},
    '{2'h2, 4'hF, 4'hC, 8'h01}};
  logic i_core_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [9:0] i_sa;
  logic i_aen, i_ior_n, i_iow_n, o_sd_oe;
  logic [7:0] i_sd, o_sd, d;
  logic i_base_select_jumper_a = 1'b0, i_base_select_jumper_b = 1'b0;
  logic i_irq_select_jumper_first = 1'b0, i_irq_select_jumper_second = 1'b0;
  logic i_irq_select_jumper_third = 1'b0, i_wide_mode_jumper = 1'b0;
  logic i_mac_irq = 1'b0;
  logic [2:0] o_host_irq;
  logic o_mac_cs_n, o_mac_wide_mode, o_bus_power_en, got;
  logic [9:0] base;
  bus_state_type o_bus_state;
  int failures = 0;
  int total_checks = 0;
  always #25 i_core_clk = ~i_core_clk;
  // board code is arbitrary; the revision differs from the default
  board_regs #(.BOARD_ID(4'hA), .LOGIC_REVISION(4'h3)) i_dut (.*);
  isa_host i_host (.i_clk(i_core_clk), .i_sd(o_sd), .i_sd_oe(o_sd_oe),
    .o_sa(i_sa), .o_aen(i_aen), .o_ior_n(i_ior_n), .o_iow_n(i_iow_n),
    .o_sd(i_sd));
  task automatic chk(input string what, input logic [7:0] seen,
      input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // jumpers move only between cycles; image settles in two edges
  task automatic jump(input logic [1:0] s, input logic [3:0] j);
    @(posedge i_core_clk);
    {i_base_select_jumper_b, i_base_select_jumper_a} <= s;
    {i_irq_select_jumper_third, i_irq_select_jumper_second,
      i_irq_select_jumper_first, i_wide_mode_jumper} <= j;
    repeat (2) @(posedge i_core_clk);
  endtask
  task automatic complete_run();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge i_core_clk);
    failures++;
    complete_run();
  end
  initial begin
    repeat (12) @(posedge i_core_clk);
    i_rst <= 1'b0;
    @(posedge i_core_clk);
    chk("power reset", {7'h00, o_bus_power_en}, 8'h01);
    for (int i = 0; i < 8; i++) begin
      jump(ROWS[i].sel, ROWS[i].jmp);
      base = 10'h100 + {4'h0, ROWS[i].sel, 4'h0};
      i_host.rd(base + {6'h00, ROWS[i].off}, 1'b0, d, got);
      chk("register", d, ROWS[i].exp);
      chk("wide mode", {7'h00, o_mac_wide_mode}, {7'h00, ROWS[i].jmp[0]});
      i_host.put(MAC[ROWS[i].sel] + 10'h01F);
      chk("mac select in", {7'h00, o_mac_cs_n}, 8'h00);
      i_host.put(MAC[ROWS[i].sel] + 10'h020);
      chk("mac select out", {7'h00, o_mac_cs_n}, 8'h01);
    end
    $display("test rows done");
    i_host.wr(base + 10'h00C, 8'hFE);
    chk("power off", {7'h00, o_bus_power_en}, 8'h00);
    i_host.rd(base + 10'h00C, 1'b0, d, got);
    chk("reserved bits", d, 8'h00);
    i_host.wr(base + 10'h00C, 8'h01);
    i_host.rd(base + 10'h00C, 1'b0, d, got);
    chk("power on", d, 8'h01);
    i_host.wr(base, 8'h0E);
    i_host.rd(base, 1'b0, d, got);
    chk("id kept", d, 8'h0A);
    i_host.rd(base + 10'h001, 1'b0, d, got);
    chk("unmapped", {7'h00, got}, 8'h00);
    i_host.rd(base, 1'b1, d, got);
    chk("dma cycle", {7'h00, got}, 8'h00);
    i_host.rd(10'h100, 1'b0, d, got);
    chk("other base", {7'h00, got}, 8'h00);
    $display("test access done");
    for (int i = 0; i < 3; i++) begin
      jump(2'h0, 4'h2 << i);
      i_mac_irq <= 1'b1;
      repeat (2) @(posedge i_core_clk);
      chk("irq line", {5'h00, o_host_irq}, 8'h01 << i);
      i_mac_irq <= 1'b0;
      repeat (2) @(posedge i_core_clk);
      chk("irq idle", {5'h00, o_host_irq}, 8'h00);
    end
    $display("test irq done");
    i_host.wr(10'h10C, 8'h00);
    chk("power before reset", {7'h00, o_bus_power_en}, 8'h00);
    rst_pulse();
    chk("power after reset", {7'h00, o_bus_power_en}, 8'h01);
    chk("phase after reset", {6'h00, o_bus_state}, 8'h00);
    $display("test reset done");
    complete_run();
  end
  task automatic rst_pulse();
    @(posedge i_core_clk);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_core_clk);
    i_rst <= 1'b0;
    @(posedge i_core_clk);
  endtask
endmodule // tb_board_regs
`default_nettype wire
